// ===== rtl/cfs_params.svh
// Constants for the converter fault status byte bank.
// Assumes inclusion by name from rtl/; holds definitions only.
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// =====================================================
// Command codes
`define CFS_CMD_IOUT 8'h7b
`define CFS_CMD_INPUT 8'h7c
`define CFS_CMD_TEMP 8'h7d
`define CFS_CMD_CML 8'h7e

// =====================================================
// Reset values
`define CFS_RESET_BYTE 8'h00

// =====================================================
// Bit positions
`define CFS_OUT_OVERCURRENT_FAULT_BIT 7
`define CFS_OUT_OVERCURRENT_WARNING_BIT 5
`define CFS_IN_OVF_BIT 7
`define CFS_IN_UVF_BIT 4
`define CFS_IN_OCF_BIT 2
`define CFS_IN_OCW_BIT 1
`define CFS_TEMP_OTF_BIT 7
`define CFS_TEMP_OTW_BIT 6
`define CFS_CML_CMD_BIT 7
`define CFS_CML_DATA_BIT 6
`define CFS_CML_PEC_BIT 5
`define CFS_CML_MEM_BIT 4
`define CFS_CML_COM_BIT 1

// =====================================================
// Masks of supported bits; all other bits read zero
`define CFS_IOUT_MASK 8'ha0
`define CFS_INPUT_MASK 8'h96
`define CFS_TEMP_MASK 8'hc0
`define CFS_CML_MASK 8'hf2

`endif

// ===== rtl/cfs_pkg.sv
// Types for the converter fault status byte bank.
// Assumes nothing of its surroundings.
package cfs_pkg;

    // =====================================================
    // Fault event strobes, one bit each
    typedef struct packed {
        logic outOcFault;
        logic outOcWarn;
        logic inOvFault;
        logic inUvFault;
        logic inOcFault;
        logic inOcWarn;
        logic otFault;
        logic otWarn;
        logic badCommand;
        logic badData;
        logic packetCheckError;
        logic nvWriteBlocked;
        logic otherCommFault;
    } cfs_events_t;

    typedef enum logic [3:0] {
        CFS_SEL_IOUT = 4'h1,
        CFS_SEL_INPUT = 4'h2,
        CFS_SEL_TEMP = 4'h4,
        CFS_SEL_CML = 4'h8
    } cfs_sel_t;

endpackage

// ===== rtl/cfs_flag.sv
// One latched fault flag: set by event, held until clear or reset.
// Assumes event and clear are synchronous to clk.
`timescale 1ns/1ps

module cfs_flag (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic setEvent,
    input wire logic clearReq,
    output logic flag
);

    // =====================================================
    // Latch; set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (clearReq) begin
            flag <= 1'b0;
        end
    end

    // =====================================================
    // Checks
    set_latches_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        setEvent |=> flag) else $error("flag did not latch");
    hold_without_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        flag && !clearReq |=> flag) else $error("flag dropped without clear");
    rise_needs_event_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        $rose(flag) |-> $past(setEvent)) else $error("flag rose without event");

endmodule

// ===== rtl/cfs_status_bank.sv
// Bank of read-only fault status bytes read by command code.
// Assumes fault strobes and command port are synchronous to clk;
// the serial bus engine outside decodes transactions into this port.
`timescale 1ns/1ps
`include "cfs_params.svh"

// Behaviour
// R1: Output-current byte bit 7 latches output over-current fault; zero otherwise.
// R2: Output-current byte bit 5 latches output over-current warning.
// R3: Output-current byte read by command 7Bh, reset value 00h.
// R4: Input byte read by command 7Ch, reset value 00h.
// R5: Input byte bit 7 latches input over-voltage fault.
// R6: Input byte bit 4 latches input under-voltage fault.
// R7: Input byte bit 2 latches input over-current fault.
// R8: Input byte bit 1 latches input over-current warning.
// R9: Temperature byte read by command 7Dh, reset value 00h.
// R10: Temperature byte bit 7 latches over-temperature fault.
// R11: Temperature byte bit 6 latches over-temperature warning.
// R12: Communication byte read by command 7Eh, reset value 00h.
// R13: Communication bit 7 latches invalid or unsupported command received.
// R14: Communication bit 6 latches invalid or unsupported data received.
// R15: Communication bit 5 latches packet error check failure.
// R16: Communication bit 4 latches write attempt during non-volatile programming.
// R17: Communication bit 1 latches any other communication fault.
// R18: Unsupported and reserved bits always read zero.
// R19: Flags hold until host clear request or reset.
// R20: Host writes never change status byte contents; here a write still sets communication bit 7, 6 or 4 as a fault.
module cfs_status_bank
    import cfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input cfs_events_t faultEvents,
    input wire logic nonvolatile_store,
    input wire logic readReq,
    input wire logic writeReq,
    input wire logic [7:0] cmdCode,
    input wire logic clearAll,
    output logic readAck,
    output logic readValid,
    output logic [7:0] readData,
    output logic cmdUnknown
);

    localparam int NFLAG = 13;

    // =====================================================
    // Event vector, ordered as the flag bank below
    logic [NFLAG-1:0] setVec;
    logic [NFLAG-1:0] flagVec;
    logic isKnown;
    logic writeBlocked;

    always_comb begin
        case (cmdCode)
            `CFS_CMD_IOUT, `CFS_CMD_INPUT, `CFS_CMD_TEMP, `CFS_CMD_CML: begin
                isKnown = 1'b1;
            end
            default: begin
                isKnown = 1'b0;
            end
        endcase
    end

    // Any write while programming the store is a memory error [R16]
    assign writeBlocked = writeReq && nonvolatile_store;

    assign setVec = {
        faultEvents.outOcFault,
        faultEvents.outOcWarn,
        faultEvents.inOvFault,
        faultEvents.inUvFault,
        faultEvents.inOcFault,
        faultEvents.inOcWarn,
        faultEvents.otFault,
        faultEvents.otWarn,
        faultEvents.badCommand || ((readReq || writeReq) && !isKnown), // [R13]
        faultEvents.badData || (writeReq && isKnown), // [R14]
        faultEvents.packetCheckError, // [R15]
        faultEvents.nvWriteBlocked || writeBlocked, // [R16]
        faultEvents.otherCommFault // [R17]
    };

    // =====================================================
    // Latched flags
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : gFlag
            cfs_flag uFlag (
                .clk(clk),
                .rst_b(rst_b),
                .setEvent(setVec[gi]),
                .clearReq(clearAll), // [R19]
                .flag(flagVec[gi])
            );
        end
    endgenerate

    // =====================================================
    // Byte assembly; unsupported bits tied to zero
    logic [7:0] ioutByte;
    logic [7:0] inputByte;
    logic [7:0] tempByte;
    logic [7:0] cmlByte;

    always_comb begin
        ioutByte = `CFS_RESET_BYTE;
        inputByte = `CFS_RESET_BYTE;
        tempByte = `CFS_RESET_BYTE;
        cmlByte = `CFS_RESET_BYTE;
        ioutByte[`CFS_OUT_OVERCURRENT_FAULT_BIT] = flagVec[12]; // [R1]
        ioutByte[`CFS_OUT_OVERCURRENT_WARNING_BIT] = flagVec[11]; // [R2]
        inputByte[`CFS_IN_OVF_BIT] = flagVec[10]; // [R5]
        inputByte[`CFS_IN_UVF_BIT] = flagVec[9]; // [R6]
        inputByte[`CFS_IN_OCF_BIT] = flagVec[8]; // [R7]
        inputByte[`CFS_IN_OCW_BIT] = flagVec[7]; // [R8]
        tempByte[`CFS_TEMP_OTF_BIT] = flagVec[6]; // [R10]
        tempByte[`CFS_TEMP_OTW_BIT] = flagVec[5]; // [R11]
        cmlByte[`CFS_CML_CMD_BIT] = flagVec[4];
        cmlByte[`CFS_CML_DATA_BIT] = flagVec[3];
        cmlByte[`CFS_CML_PEC_BIT] = flagVec[2];
        cmlByte[`CFS_CML_MEM_BIT] = flagVec[1];
        cmlByte[`CFS_CML_COM_BIT] = flagVec[0];
    end

    // =====================================================
    // Read port; writes reach only communication bits 7, 6 and 4, as faults [R20]
    logic [7:0] next_readData;
    cfs_sel_t sel;

    always_comb begin
        sel = CFS_SEL_IOUT;
        next_readData = `CFS_RESET_BYTE;
        case (cmdCode)
            `CFS_CMD_IOUT: begin
                sel = CFS_SEL_IOUT;
            end
            `CFS_CMD_INPUT: begin
                sel = CFS_SEL_INPUT;
            end
            `CFS_CMD_TEMP: begin
                sel = CFS_SEL_TEMP;
            end
            default: begin
                sel = CFS_SEL_CML;
            end
        endcase
        case (sel)
            CFS_SEL_IOUT: begin
                next_readData = ioutByte & `CFS_IOUT_MASK; // [R3] [R18]
            end
            CFS_SEL_INPUT: begin
                next_readData = inputByte & `CFS_INPUT_MASK; // [R4] [R18]
            end
            CFS_SEL_TEMP: begin
                next_readData = tempByte & `CFS_TEMP_MASK; // [R9] [R18]
            end
            CFS_SEL_CML: begin
                next_readData = cmlByte & `CFS_CML_MASK; // [R12] [R18]
            end
            default: begin
                next_readData = `CFS_RESET_BYTE;
            end
        endcase
        if (!isKnown) begin
            next_readData = `CFS_RESET_BYTE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            readData <= `CFS_RESET_BYTE;
            readValid <= 1'b0;
            cmdUnknown <= 1'b0;
        end else begin
            readValid <= readReq && isKnown;
            cmdUnknown <= (readReq || writeReq) && !isKnown;
            if (readReq) begin
                readData <= next_readData;
            end
        end
    end

    // Handshake is combinational: every read is taken at once
    assign readAck = readReq;

    // =====================================================
    // Read port checks
    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
        readValid |-> (readData & ~(`CFS_IOUT_MASK | `CFS_INPUT_MASK
            | `CFS_TEMP_MASK | `CFS_CML_MASK)) == 8'h00)
        else $error("reserved bit set");
    // A flag set in the request cycle only shows in the next read
    iout_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        readReq && cmdCode == `CFS_CMD_IOUT && !clearAll |=>
            readData == {flagVec[12], 1'b0, flagVec[11], 5'h00} || $past(|setVec))
        else $error("output-current byte wrong");
    // Byte layouts written out bit by bit, not taken from the mux above
    input_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        readReq && cmdCode == `CFS_CMD_INPUT |=> readData == {$past(flagVec[10]), 2'b00,
            $past(flagVec[9]), 1'b0, $past(flagVec[8]), $past(flagVec[7]), 1'b0})
        else $error("input byte wrong");
    temp_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        readReq && cmdCode == `CFS_CMD_TEMP |=>
            readData == {$past(flagVec[6]), $past(flagVec[5]), 6'h00})
        else $error("temperature byte wrong");
    cml_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        readReq && cmdCode == `CFS_CMD_CML |=> readData == {$past(flagVec[4]),
            $past(flagVec[3]), $past(flagVec[2]), $past(flagVec[1]), 2'b00,
            $past(flagVec[0]), 1'b0})
        else $error("communication byte wrong");
    input_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        readReq && cmdCode == `CFS_CMD_INPUT |=> (readData & 8'h69) == 8'h00)
        else $error("input reserved bits set");
    temp_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        readReq && cmdCode == `CFS_CMD_TEMP |=> readData[5:0] == 6'h00)
        else $error("temperature low bits set");
    cml_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        readReq && cmdCode == `CFS_CMD_CML |=> (readData & 8'h0d) == 8'h00)
        else $error("communication reserved bits set");
    read_valid_a: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        readReq && isKnown |=> readValid)
        else $error("known read gave no valid");
    valid_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        !(readReq && isKnown) |=> !readValid)
        else $error("valid without a known read");
    // Host sees the last byte read until it asks again
    data_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
        !readReq |=> $stable(readData))
        else $error("read data moved without a read");
    unknown_data_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        readReq && !isKnown |=> readData == 8'h00 && !readValid)
        else $error("unknown read returned data");
    write_no_valid_a: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
        writeReq && !readReq |=> !readValid)
        else $error("write answered as a read");

    // =====================================================
    // Flag checks: each event shows in its byte one cycle later
    iout_fault_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        faultEvents.outOcFault ##1 (readReq && cmdCode == `CFS_CMD_IOUT)
            |=> readData[`CFS_OUT_OVERCURRENT_FAULT_BIT])
        else $error("fault not reported");
    iout_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !ioutByte[`CFS_OUT_OVERCURRENT_FAULT_BIT] && !faultEvents.outOcFault
            |=> !ioutByte[`CFS_OUT_OVERCURRENT_FAULT_BIT])
        else $error("over-current flag set without fault");
    iout_warn_a: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        faultEvents.outOcWarn |=> ioutByte[`CFS_OUT_OVERCURRENT_WARNING_BIT])
        else $error("current warning not latched");
    in_ovf_a: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        faultEvents.inOvFault |=> inputByte[`CFS_IN_OVF_BIT])
        else $error("input over-voltage not latched");
    in_uvf_a: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        faultEvents.inUvFault |=> inputByte[`CFS_IN_UVF_BIT])
        else $error("input under-voltage not latched");
    in_ocf_a: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        faultEvents.inOcFault |=> inputByte[`CFS_IN_OCF_BIT])
        else $error("input over-current not latched");
    in_ocw_a: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        faultEvents.inOcWarn |=> inputByte[`CFS_IN_OCW_BIT])
        else $error("input current warning not latched");
    temp_otf_a: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        faultEvents.otFault |=> tempByte[`CFS_TEMP_OTF_BIT])
        else $error("over-temperature fault not latched");
    temp_otw_a: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        faultEvents.otWarn |=> tempByte[`CFS_TEMP_OTW_BIT])
        else $error("over-temperature warning not latched");
    bad_cmd_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        readReq && !isKnown |=> flagVec[4] && cmdUnknown)
        else $error("bad command not flagged");
    cml_data_a: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        writeReq && isKnown |=> cmlByte[`CFS_CML_DATA_BIT])
        else $error("bad data not flagged");
    cml_pec_a: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        faultEvents.packetCheckError |=> cmlByte[`CFS_CML_PEC_BIT])
        else $error("packet check error not latched");
    mem_error_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        writeReq && nonvolatile_store |=> flagVec[1])
        else $error("memory error not flagged");
    cml_mem_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        faultEvents.nvWriteBlocked |=> cmlByte[`CFS_CML_MEM_BIT])
        else $error("memory error strobe not latched");
    cml_other_a: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
        faultEvents.otherCommFault |=> cmlByte[`CFS_CML_COM_BIT])
        else $error("other comm fault not latched");

    // =====================================================
    // Refusal checks
    write_nochange_a: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
        writeReq && !clearAll && !(|faultEvents) && !readReq |=>
            ($stable(flagVec[12:5])))
        else $error("write changed a fault byte");
    write_unknown_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        writeReq && !isKnown |=> cmdUnknown && cmlByte[`CFS_CML_CMD_BIT] && !readValid)
        else $error("unknown write not flagged");
    known_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        (readReq || writeReq) && isKnown && !faultEvents.badCommand && !flagVec[4]
            |=> !flagVec[4] && !cmdUnknown)
        else $error("known code flagged as bad");
    unknown_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        !((readReq || writeReq) && !isKnown) |=> !cmdUnknown)
        else $error("unknown pulse without a request");
    // Unknown codes are a command fault, never also a data fault
    unknown_no_data_a: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        writeReq && !isKnown && !faultEvents.badData && !flagVec[3] |=> !flagVec[3])
        else $error("unknown write flagged as bad data");
    no_stray_mem_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        !writeBlocked && !faultEvents.nvWriteBlocked && !flagVec[1] |=> !flagVec[1])
        else $error("memory error without blocked write");

    // =====================================================
    // Clear and reset checks
    clear_works_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        clearAll && !(|setVec) |=> flagVec == '0)
        else $error("clear did not clear");
    clear_then_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        clearAll && !(|setVec) ##1 (readReq && isKnown && !(|setVec))
            |=> readData == 8'h00)
        else $error("cleared byte read nonzero");
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        !clearAll |=> (flagVec & $past(flagVec)) == $past(flagVec))
        else $error("flag dropped without clear");
    // No disable here: the reset cycles themselves are what is checked
    reset_clear_a: assert property (@(posedge clk) // [R19]
        !rst_b |=> flagVec == '0 && readData == 8'h00 && !readValid && !cmdUnknown)
        else $error("reset left state behind");

    // =====================================================
    // Coverage of the main scenarios
    read_iout_c: cover property (@(posedge clk) disable iff (!rst_b)
        readValid && readData[`CFS_OUT_OVERCURRENT_FAULT_BIT]);
    read_temp_c: cover property (@(posedge clk) disable iff (!rst_b)
        faultEvents.otWarn ##1 readReq && cmdCode == `CFS_CMD_TEMP);
    // Event and clear together: the set must win
    set_clear_c: cover property (@(posedge clk) disable iff (!rst_b)
        setVec[0] && clearAll);
    blocked_c: cover property (@(posedge clk) disable iff (!rst_b) writeBlocked);
    unknown_write_c: cover property (@(posedge clk) disable iff (!rst_b)
        writeReq && !isKnown);

endmodule

// ===== testbench/cfs_host_model.sv
// Host model: issues one-byte reads, write attempts and clear requests.
// Assumes the status bank samples requests on the rising edge of clk.
`timescale 1ns/1ps

module cfs_host_model (
    input wire logic clk,
    output logic readReq,
    output logic writeReq,
    output logic [7:0] cmdCode,
    output logic clearAll,
    input wire logic readAck,
    input wire logic readValid,
    input wire logic [7:0] readData,
    input wire logic cmdUnknown
);
    logic [7:0] lastData;
    logic lastValid;
    logic lastAck;
    logic lastUnknown;

    initial begin
        readReq = 1'b0;
        writeReq = 1'b0;
        clearAll = 1'b0;
        cmdCode = 8'h00;
    end

    // =====================================================
    // Requests
    // Kind is {read, write, clear}; besides reset, a clear is the only way flags drop
    task automatic request(input logic [2:0] kind, input logic [7:0] code);
        @(posedge clk);
        {readReq, writeReq, clearAll} <= kind;
        cmdCode <= code;
        @(posedge clk);
        // Ack is combinational, so it is taken at the request edge
        lastAck = readAck;
        {readReq, writeReq, clearAll} <= 3'b000;
        // Code is not held after the request edge
        cmdCode <= ~code;
        // Registered answer stands through the next edge
        @(posedge clk);
        lastData = readData;
        lastValid = readValid;
        lastUnknown = cmdUnknown;
    endtask
endmodule

// ===== testbench/cfs_status_bank_tb.sv
// Self-checking bench for the fault status byte bank.
// Assumes the host model drives the command port; bench drives events.
`timescale 1ns/1ps

module cfs_status_bank_tb import cfs_pkg::*;;
    logic clk;
    logic rst_b;
    cfs_events_t faultEvents;
    logic nonvolatile_store;
    logic readReq;
    logic writeReq;
    logic [7:0] cmdCode;
    logic clearAll;
    logic readAck;
    logic readValid;
    logic [7:0] readData;
    logic cmdUnknown;
    int num_errors;
    int checks_done;
    // Per event, outOcFault first: byte code and expected bit
    logic [7:0] evCode [13] = '{8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7c, 8'h7c, 8'h7d,
        8'h7d, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e};
    logic [7:0] evBit [13] = '{8'h80, 8'h20, 8'h80, 8'h10, 8'h04, 8'h02, 8'h80,
        8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h02};

    cfs_status_bank cfs_status_bank_i (.clk(clk), .rst_b(rst_b), .faultEvents(faultEvents),
        .nonvolatile_store(nonvolatile_store), .readReq(readReq), .writeReq(writeReq),
        .cmdCode(cmdCode), .clearAll(clearAll), .readAck(readAck), .readValid(readValid),
        .readData(readData), .cmdUnknown(cmdUnknown));

    cfs_host_model cfs_host_model_i (.clk(clk), .readReq(readReq), .writeReq(writeReq),
        .cmdCode(cmdCode), .clearAll(clearAll), .readAck(readAck), .readValid(readValid),
        .readData(readData), .cmdUnknown(cmdUnknown));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // =====================================================
    // Reporting
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =====================================================
    // Helpers
    task automatic readCheck(input logic [7:0] code, input logic [7:0] exp);
        cfs_host_model_i.request(3'b100, code);
        check(cfs_host_model_i.lastData, exp);
        check({6'h00, cfs_host_model_i.lastAck, cfs_host_model_i.lastValid}, 8'h03);
        check({7'h00, cfs_host_model_i.lastUnknown}, 8'h00);
    endtask

    task automatic fire(input logic [12:0] mask);
        @(posedge clk);
        faultEvents <= cfs_events_t'(mask);
        @(posedge clk);
        faultEvents <= cfs_events_t'(13'h0000);
    endtask

    // =====================================================
    // Scenarios
    task automatic testDefaults();
        for (int c = 8'h7b; c <= 8'h7e; c++) begin
            readCheck(8'(c), 8'h00);
        end
    endtask

    task automatic testEachEvent();
        for (int i = 0; i < 13; i++) begin
            fire(13'h1000 >> i);
            // Condition gone for several cycles; flag must stay
            repeat (3) @(posedge clk);
            readCheck(evCode[i], evBit[i]);
            cfs_host_model_i.request(3'b001, 8'h00);
            readCheck(evCode[i], 8'h00);
        end
    endtask

    task automatic testAllMasks();
        logic [7:0] masks [4];
        masks = '{8'ha0, 8'h96, 8'hc0, 8'hf2};
        fire(13'h1fff);
        for (int k = 0; k < 4; k++) begin
            readCheck(8'h7b + 8'(k), masks[k]);
            cfs_host_model_i.request(3'b010, 8'h7b + 8'(k));
            readCheck(8'h7b + 8'(k), masks[k]);
        end
        cfs_host_model_i.request(3'b001, 8'h00);
    endtask

    task automatic testRefusals();
        cfs_host_model_i.request(3'b010, 8'h7b);
        check({7'h00, cfs_host_model_i.lastAck}, 8'h00);
        readCheck(8'h7b, 8'h00);
        readCheck(8'h7e, 8'h40);
        cfs_host_model_i.request(3'b001, 8'h00);
        nonvolatile_store <= 1'b1;
        cfs_host_model_i.request(3'b010, 8'h7c);
        nonvolatile_store <= 1'b0;
        readCheck(8'h7e, 8'h50);
        cfs_host_model_i.request(3'b001, 8'h00);
        cfs_host_model_i.request(3'b100, 8'h7a);
        check(cfs_host_model_i.lastData, 8'h00);
        check({7'h00, cfs_host_model_i.lastValid}, 8'h00);
        check({7'h00, cfs_host_model_i.lastUnknown}, 8'h01);
        readCheck(8'h7e, 8'h80);
        // Unknown write is a bad command only, never bad data
        cfs_host_model_i.request(3'b001, 8'h00);
        cfs_host_model_i.request(3'b010, 8'h7f);
        check({7'h00, cfs_host_model_i.lastUnknown}, 8'h01);
        readCheck(8'h7e, 8'h80);
        cfs_host_model_i.request(3'b001, 8'h00);
    endtask

    task automatic testSetWins();
        // Event and clear in one cycle: the event must survive
        fork
            fire(13'h0001);
            cfs_host_model_i.request(3'b001, 8'h00);
        join
        readCheck(8'h7e, 8'h02);
        cfs_host_model_i.request(3'b001, 8'h00);
        readCheck(8'h7e, 8'h00);
    endtask

    task automatic testMidReset();
        // Reset in mid-run drops every latched flag and the read data
        fire(13'h0030);
        readCheck(8'h7d, 8'h40);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        check(readData, 8'h00);
        check({6'h00, readValid, cmdUnknown}, 8'h00);
        readCheck(8'h7d, 8'h00);
        readCheck(8'h7e, 8'h00);
    endtask

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        faultEvents = cfs_events_t'(13'h0000);
        nonvolatile_store = 1'b0;
        num_errors = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        testDefaults();
        testEachEvent();
        testAllMasks();
        testRefusals();
        testSetWins();
        testMidReset();
        print_verdict();
    end
endmodule
